// file: field_memory_pkg.sv
package field_memory_pkg;

   // pointer field widths
   localparam int LINE_W = 9;
   localparam int DOT_W = 11;
   localparam int WORD_W = 19;
   localparam int JUMP_W = 15;
   localparam int NBITS_W = 4;

   // jump address length in serial bits
   localparam logic [NBITS_W-1:0] JUMP_BITS_NARROW = 4'he;
   localparam logic [NBITS_W-1:0] JUMP_BITS_WIDE = 4'hf;

   // last positions of the address spaces
   localparam logic [WORD_W-1:0] FIFO_WORD_LAST = 19'h50fff;
   localparam logic [DOT_W-1:0] DOT_LAST_NARROW = 11'h3ff;
   localparam logic [DOT_W-1:0] DOT_LAST_WIDE = 11'h47f;
   localparam logic [LINE_W-1:0] LINE_LAST_NARROW = 9'h143;
   localparam logic [LINE_W-1:0] LINE_LAST_WIDE = 9'h11f;

   // values after reset, and the pointer home position
   localparam logic [LINE_W-1:0] LINE_RST = 9'h000;
   localparam logic [DOT_W-1:0] DOT_RST = 11'h000;
   localparam logic [WORD_W-1:0] WORD_RST = 19'h00000;
   localparam logic [JUMP_W-1:0] JUMP_RST = 15'h0000;

   // bit positions inside a side's synchronised pin vector
   localparam int PIN_W = 9;
   localparam int PIN_CLK = 0;
   localparam int PIN_RS_N = 1;
   localparam int PIN_AS_N = 2;
   localparam int PIN_LR_N = 3;
   localparam int PIN_WIN_N = 4;
   localparam int PIN_CLR_N = 5;
   localparam int PIN_GATE_N = 6;
   localparam int PIN_EN_N = 7;
   localparam int PIN_DATA = 8;
   localparam logic [PIN_W-1:0] PIN_RST = 9'h1ff;

   typedef enum logic [3:0] {
      OP_IDLE,
      OP_NORMAL,
      OP_RESET,
      OP_JUMP,
      OP_SETUP,
      OP_LINE_INC,
      OP_LINE_HOLD,
      OP_WIN_JUMP,
      OP_WIN_RESET,
      OP_CLEAR
   } op_t;

endpackage : field_memory_pkg

// file: field_memory_pointer_control.sv
`timescale 1ns/1ps
// Functional notes
// - pointer operations act only while the side's clock gate is low
// - 1-D write: both strobes high advance the write pointer by one
// - 1-D write: reset low, address strobe high sends pointer to 0
// - 1-D write: both strobes low jump to the stored jump address
// - 1-D write: reset high, address low shifts in jump address, pointer held
// - 1-D read: both strobes high advance the read pointer by one
// - 1-D read: reset low, address strobe high sends pointer to 0
// - 1-D read: both strobes low jump to the stored jump address
// - 1-D read: reset high, address low shifts in jump address, pointer held
// - 2-D write pointer stops at its line's last dot
// - write line increment goes to first dot of next line at once
// - read line increment goes to first dot of next line at once
// - line hold returns pointer to first dot of the current line
// - in window mode line increment goes to window left edge, next line
// - in window mode line hold goes to window left edge, same line
// - window reset returns pointer to the window origin, the jump address
// - jump with window select low turns window scanning on
// - in window mode pointer still stops at its line's last address
// - clear sends pointer to zero regardless and ends window scanning
module field_memory_pointer_control
   import field_memory_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // addressing mode straps
   input wire logic two_dim_mode,
   input wire logic wide_line_mode,
   // write side pins
   input wire logic write_clock,
   input wire logic write_reset_strobe_n,
   input wire logic write_addr_strobe_n,
   input wire logic write_line_reset_n,
   input wire logic write_window_sel_n,
   input wire logic write_clear_strobe_n,
   input wire logic write_clock_gate_n,
   input wire logic write_enable_n,
   input wire logic write_jump_data,
   // read side pins
   input wire logic read_clock,
   input wire logic read_reset_strobe_n,
   input wire logic read_addr_strobe_n,
   input wire logic read_line_reset_n,
   input wire logic read_window_sel_n,
   input wire logic read_clear_strobe_n,
   input wire logic read_clock_gate_n,
   input wire logic read_enable_n,
   input wire logic read_jump_data,
   // write pointer state
   output logic [WORD_W-1:0] write_word_addr,
   output logic [LINE_W-1:0] write_line,
   output logic [DOT_W-1:0] write_dot,
   output logic write_window_on,
   output logic write_line_end,
   output logic write_access,
   output logic write_setup_busy,
   output logic [JUMP_W-1:0] write_jump_addr,
   // read pointer state
   output logic [WORD_W-1:0] read_word_addr,
   output logic [LINE_W-1:0] read_line,
   output logic [DOT_W-1:0] read_dot,
   output logic read_window_on,
   output logic read_line_end,
   output logic read_access,
   output logic read_setup_busy,
   output logic [JUMP_W-1:0] read_jump_addr
);

   function automatic op_t decode_op(
      input logic two_d,
      input logic rs_n,
      input logic as_n,
      input logic lr_n,
      input logic win_n,
      input logic clr_n
   );
      op_t op;
      op = OP_NORMAL;
      if (!two_d) begin
         // line reset, window and clear pins mean nothing in 1-d
         unique case ({rs_n, as_n})
            2'b11: op = OP_NORMAL;
            2'b01: op = OP_RESET;
            2'b00: op = OP_JUMP;
            2'b10: op = OP_SETUP;
         endcase
      end else if (!clr_n) begin
         op = OP_CLEAR;
      end else begin
         // window select high picks the plain forms
         unique case ({rs_n, as_n, lr_n})
            3'b111: op = OP_NORMAL;
            3'b011: op = win_n ? OP_RESET : OP_WIN_RESET;
            3'b001: op = win_n ? OP_JUMP : OP_WIN_JUMP;
            3'b101: op = OP_SETUP;
            3'b110: op = OP_LINE_INC;
            3'b010: op = OP_LINE_HOLD;
            // 100 and 000 are undefined; counting on is the safe guess
            default: op = OP_NORMAL;
         endcase
      end
      return op;
   endfunction : decode_op

   // any pointer reposition, as opposed to counting or setup
   function automatic logic is_sys_reset(input op_t op);
      return !(op == OP_IDLE || op == OP_NORMAL || op == OP_SETUP);
   endfunction : is_sys_reset

   logic [1:0] mode_q;
   logic mode_2d;
   logic mode_wide;
   logic [NBITS_W-1:0] nbits;
   logic [LINE_W-1:0] line_last;
   logic [DOT_W-1:0] dot_last;
   logic [PIN_W-1:0] side_pins [2];
   logic [WORD_W-1:0] word_q [2];
   logic [LINE_W-1:0] line_q [2];
   logic [DOT_W-1:0] dot_q [2];
   logic [JUMP_W-1:0] jump_q [2];
   logic win_q [2];
   logic end_q [2];
   logic access_q [2];
   logic busy_q [2];

   // straps are slow but still cross into ref_clk
   pin_sync #(
      .W(2)
   ) u_mode_sync (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .pin_in({wide_line_mode, two_dim_mode}),
      .pin_q(mode_q),
      .rise()
   );

   assign mode_2d = mode_q[0];
   assign mode_wide = mode_q[1];
   assign nbits = (mode_2d && mode_wide) ? JUMP_BITS_WIDE : JUMP_BITS_NARROW;
   assign line_last = mode_wide ? LINE_LAST_WIDE : LINE_LAST_NARROW;
   assign dot_last = mode_wide ? DOT_LAST_WIDE : DOT_LAST_NARROW;

   assign side_pins[0] = {write_jump_data, write_enable_n,
      write_clock_gate_n, write_clear_strobe_n, write_window_sel_n,
      write_line_reset_n, write_addr_strobe_n, write_reset_strobe_n,
      write_clock};
   assign side_pins[1] = {read_jump_data, read_enable_n,
      read_clock_gate_n, read_clear_strobe_n, read_window_sel_n,
      read_line_reset_n, read_addr_strobe_n, read_reset_strobe_n,
      read_clock};

   // index 0 is the write system, 1 the read system; they never interact
   for (genvar i = 0; i < 2; i++) begin : g_side
      logic [PIN_W-1:0] pin_q;
      logic edge_p;
      logic gate_open;
      op_t op_now;
      op_t op_do;
      op_t pend_r;
      logic [WORD_W-1:0] word_r;
      logic [LINE_W-1:0] line_r;
      logic [DOT_W-1:0] dot_r;
      logic win_r;
      logic access_r;
      logic [LINE_W-1:0] j_line;
      logic [DOT_W-1:0] j_dot;
      logic [WORD_W-1:0] j_word;
      logic [DOT_W-1:0] left_dot;
      logic [LINE_W-1:0] next_line;

      // pin clock must be well below ref_clk, strobes held past its edge
      pin_sync #(
         .W(PIN_W)
      ) u_sync (
         .ref_clk(ref_clk),
         .nrst(nrst),
         .pin_in(side_pins[i]),
         .pin_q(pin_q),
         .rise(edge_p)
      );

      assign gate_open = ~pin_q[PIN_GATE_N];
      assign op_now = decode_op(mode_2d, pin_q[PIN_RS_N], pin_q[PIN_AS_N],
         pin_q[PIN_LR_N], pin_q[PIN_WIN_N], pin_q[PIN_CLR_N]);

      // setup shifts regardless of the clock gate
      jump_addr_load u_jump (
         .ref_clk(ref_clk),
         .nrst(nrst),
         .step(edge_p),
         .start(op_now == OP_SETUP),
         .addr_strobe_n(pin_q[PIN_AS_N]),
         .data(pin_q[PIN_DATA]),
         .nbits(nbits),
         .jump_addr(jump_q[i]),
         .busy(busy_q[i])
      );

      // while gated only the first reposition is kept, run on reopening
      // later ones are dropped, not queued, so a burst costs nothing
      always_ff @(posedge ref_clk or negedge nrst) begin
         if (!nrst) begin
            pend_r <= OP_IDLE;
         end else if (edge_p) begin
            if (gate_open) begin
               pend_r <= OP_IDLE;
            end else if (pend_r == OP_IDLE && is_sys_reset(op_now)) begin
               pend_r <= op_now;
            end
         end
      end

      always_comb begin
         if (!gate_open) begin
            op_do = OP_IDLE;
         end else if (pend_r != OP_IDLE) begin
            op_do = pend_r;
         end else begin
            op_do = op_now;
         end
      end

      // origin follows the live jump register, hence late reloads only
      assign j_line = mode_wide ? jump_q[i][14:6] : jump_q[i][13:5];
      // read side relies on a zero horizontal block here
      assign j_dot = mode_wide ? {jump_q[i][5:0], 5'h00} :
         {1'b0, jump_q[i][4:0], 5'h00};
      assign j_word = {jump_q[i][13:0], 5'h00};
      assign left_dot = win_r ? j_dot : DOT_RST;
      // last line wraps so a line increment never sticks at the bottom
      assign next_line = (line_r == line_last) ? LINE_RST : line_r + 1'b1;

      // one-dimensional pointer
      always_ff @(posedge ref_clk or negedge nrst) begin
         if (!nrst) begin
            word_r <= WORD_RST;
         end else if (edge_p && !mode_2d) begin
            unique case (op_do)
               OP_NORMAL: begin
                  // the fifo wraps at the end of the array
                  if (word_r == FIFO_WORD_LAST) begin
                     word_r <= WORD_RST;
                  end else begin
                     word_r <= word_r + 1'b1;
                  end
               end
               OP_RESET: word_r <= WORD_RST;
               OP_JUMP: word_r <= j_word;
               default: word_r <= word_r;
            endcase
         end
      end

      // two-dimensional pointer
      // no right window edge is kept; the line end is the only stop
      always_ff @(posedge ref_clk or negedge nrst) begin
         if (!nrst) begin
            line_r <= LINE_RST;
            dot_r <= DOT_RST;
         end else if (edge_p && mode_2d) begin
            unique case (op_do)
               OP_NORMAL: begin
                  if (dot_r != dot_last) begin
                     dot_r <= dot_r + 1'b1;
                  end
               end
               OP_RESET, OP_CLEAR: begin
                  line_r <= LINE_RST;
                  dot_r <= DOT_RST;
               end
               OP_JUMP, OP_WIN_JUMP, OP_WIN_RESET: begin
                  line_r <= j_line;
                  dot_r <= j_dot;
               end
               OP_LINE_INC: begin
                  line_r <= next_line;
                  dot_r <= left_dot;
               end
               OP_LINE_HOLD: dot_r <= left_dot;
               default: dot_r <= dot_r;
            endcase
         end
      end

      // window scanning flag
      always_ff @(posedge ref_clk or negedge nrst) begin
         if (!nrst) begin
            win_r <= 1'b0;
         end else if (!mode_2d) begin
            win_r <= 1'b0;
         end else if (edge_p) begin
            unique case (op_do)
               OP_WIN_JUMP: win_r <= 1'b1;
               OP_RESET, OP_JUMP, OP_CLEAR: win_r <= 1'b0;
               default: win_r <= win_r;
            endcase
         end
      end

      // a data slot is used only on open, enabled clock edges
      // enable never blocks pointer moves, only the slot
      always_ff @(posedge ref_clk or negedge nrst) begin
         if (!nrst) begin
            access_r <= 1'b0;
         end else begin
            access_r <= edge_p & gate_open & ~pin_q[PIN_EN_N];
         end
      end

      assign word_q[i] = word_r;
      assign line_q[i] = line_r;
      assign dot_q[i] = dot_r;
      assign win_q[i] = win_r;
      assign end_q[i] = mode_2d && (dot_r == dot_last);
      assign access_q[i] = access_r;
   end

   assign write_word_addr = word_q[0];
   assign write_line = line_q[0];
   assign write_dot = dot_q[0];
   assign write_window_on = win_q[0];
   assign write_line_end = end_q[0];
   assign write_access = access_q[0];
   assign write_setup_busy = busy_q[0];
   assign write_jump_addr = jump_q[0];

   assign read_word_addr = word_q[1];
   assign read_line = line_q[1];
   assign read_dot = dot_q[1];
   assign read_window_on = win_q[1];
   assign read_line_end = end_q[1];
   assign read_access = access_q[1];
   assign read_setup_busy = busy_q[1];
   assign read_jump_addr = jump_q[1];

endmodule : field_memory_pointer_control

// file: field_memory_pointer_control_tb_top.sv
`timescale 1ns/1ps
module field_memory_pointer_control_tb_top;
   import field_memory_pkg::*;
   typedef struct packed {
      logic [WORD_W-1:0] w;
      logic [LINE_W-1:0] l;
      logic [DOT_W-1:0] d;
      logic win;
   } exp_t;
   // {rs, as, lr, win, clr, gate} pin levels
   localparam logic [5:0] NRM = 6'h3e, RST = 6'h1e, JMP = 6'h0e, SET = 6'h2e;
   localparam logic [5:0] LINC = 6'h36, LHLD = 6'h16, CLR = 6'h3c;
   localparam logic [5:0] WJMP = 6'h0a, WRST = 6'h1a;
   logic ref_clk, nrst, two_dim_mode, wide_line_mode;
   logic write_clock, write_reset_strobe_n, write_addr_strobe_n;
   logic write_line_reset_n, write_window_sel_n, write_clear_strobe_n;
   logic write_clock_gate_n, write_enable_n, write_jump_data;
   logic read_clock, read_reset_strobe_n, read_addr_strobe_n;
   logic read_line_reset_n, read_window_sel_n, read_clear_strobe_n;
   logic read_clock_gate_n, read_enable_n, read_jump_data;
   logic [WORD_W-1:0] write_word_addr, read_word_addr;
   logic [LINE_W-1:0] write_line, read_line;
   logic [DOT_W-1:0] write_dot, read_dot;
   logic [JUMP_W-1:0] write_jump_addr, read_jump_addr;
   logic write_window_on, write_line_end, write_access, write_setup_busy;
   logic read_window_on, read_line_end, read_access, read_setup_busy;
   exp_t st [2];
   exp_t q0 [$];
   exp_t q1 [$];
   logic [JUMP_W-1:0] jmp [2];
   logic [4:0] pend [2];
   bit pv [2];
   int n_errors, check_count, seed;
   wire logic [1:0] busy_v = {read_setup_busy, write_setup_busy};

   field_memory_pointer_control DUT (.*);
   video_ctl_model wc (.ref_clk(ref_clk), .ck(write_clock),
      .rs_n(write_reset_strobe_n), .as_n(write_addr_strobe_n),
      .lr_n(write_line_reset_n), .wn_n(write_window_sel_n),
      .cl_n(write_clear_strobe_n), .cg_n(write_clock_gate_n),
      .en_n(write_enable_n), .d(write_jump_data));
   video_ctl_model rc (.ref_clk(ref_clk), .ck(read_clock),
      .rs_n(read_reset_strobe_n), .as_n(read_addr_strobe_n),
      .lr_n(read_line_reset_n), .wn_n(read_window_sel_n),
      .cl_n(read_clear_strobe_n), .cg_n(read_clock_gate_n),
      .en_n(read_enable_n), .d(read_jump_data));

   always #5 ref_clk = ~ref_clk;

   task automatic chk_ptr(input string n, input logic [31:0] e,
      input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %0h seen %0h", n, e, g);
      end
   endtask : chk_ptr
   task automatic chk_bit(input string n, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %b seen %b", n, e, g);
      end
   endtask : chk_bit

   function automatic void apply(input int s, input logic [4:0] k);
      exp_t e;
      logic [DOT_W-1:0] lft;
      e = st[s];
      lft = {1'b0, jmp[s][4:0], 5'h00};
      if (!two_dim_mode) begin
         case (k[4:3])
            2'b11: e.w = (e.w == FIFO_WORD_LAST) ? WORD_RST : e.w + 19'h00001;
            2'b01: e.w = WORD_RST;
            2'b00: e.w = {jmp[s][13:0], 5'h00};
            default: ;
         endcase
      end else if (!k[0]) begin
         e.l = LINE_RST;
         e.d = DOT_RST;
         e.win = 1'b0;
      end else begin
         case (k[4:2])
            3'b111: if (e.d != DOT_LAST_NARROW) e.d = e.d + 11'h001;
            3'b011: begin
               e.l = k[1] ? LINE_RST : jmp[s][13:5];
               e.d = k[1] ? DOT_RST : lft;
               e.win = e.win && !k[1];
            end
            3'b001: begin
               e.l = jmp[s][13:5];
               e.d = lft;
               e.win = !k[1];
            end
            3'b110: begin
               e.l = (e.l == LINE_LAST_NARROW) ? LINE_RST : e.l + 9'h001;
               e.d = e.win ? lft : DOT_RST;
            end
            3'b010: e.d = e.win ? lft : DOT_RST;
            default: ;
         endcase
      end
      st[s] = e;
   endfunction : apply

   // a gated edge keeps only the first repositioning op
   task automatic op(input int s, input logic [5:0] c, input logic b);
      logic [4:0] k;
      k = c[5:1];
      if (c[0]) begin
         if (!pv[s] && !(k[4] && k[2] && k[0])) begin
            pv[s] = 1'b1;
            pend[s] = k;
         end
      end else begin
         if (pv[s]) k = pend[s];
         pv[s] = 1'b0;
         apply(s, k);
         if (s == 1) q1.push_back(st[1]);
         else q0.push_back(st[0]);
      end
      if (s == 1) rc.pulse(c, b);
      else wc.pulse(c, b);
   endtask : op
   task automatic go(input int s, input logic [5:0] c);
      op(s, c, 1'($random(seed)));
   endtask : go
   task automatic setup(input int s, input logic [JUMP_W-1:0] x);
      for (int i = 13; i >= 0; i--) begin
         op(s, SET, x[i]);
         if (i == 1) chk_bit("setup_busy", 1'b1, busy_v[s]);
      end
      jmp[s] = x;
      chk_ptr("jump_addr", 32'(x),
         32'(s ? read_jump_addr : write_jump_addr));
      chk_bit("setup_busy", 1'b0, busy_v[s]);
   endtask : setup
   function automatic logic [JUMP_W-1:0] rj(input int s);
      logic [LINE_W-1:0] l;
      logic [4:0] h;
      l = 9'(1 + {$random(seed)} % 300);
      h = (s == 1) ? 5'h00 : 5'(1 + {$random(seed)} % 30);
      return {1'b0, l, h};
   endfunction : rj

   task automatic check(input int s);
      exp_t e;
      exp_t g;
      string p;
      p = s ? "read_" : "write_";
      g = s ? {read_word_addr, read_line, read_dot, read_window_on}
         : {write_word_addr, write_line, write_dot, write_window_on};
      if ((s ? q1.size() : q0.size()) == 0) begin
         n_errors++;
         $display("[ERR] %saccess expected 0 seen 1", p);
      end else begin
         e = s ? q1.pop_front() : q0.pop_front();
         if (two_dim_mode) begin
            chk_ptr({p, "line"}, 32'(e.l), 32'(g.l));
            chk_ptr({p, "dot"}, 32'(e.d), 32'(g.d));
            chk_bit({p, "window_on"}, e.win, g.win);
         end else begin
            chk_ptr({p, "word"}, 32'(e.w),
               32'(g.w));
         end
      end
   endtask : check
   always @(negedge ref_clk) begin
      if (write_access === 1'b1) check(0);
      if (read_access === 1'b1) check(1);
   end

   task automatic p1(input int s);
      go(s, RST);
      repeat (3) go(s, NRM);
      setup(s, 15'(1 + {$random(seed)} % 10366));
      go(s, JMP);
      go(s, NRM);
      if (s == 1) begin
         go(s, NRM | 6'h01);
         go(s, RST | 6'h01);
         go(s, JMP | 6'h01);
         go(s, NRM);
      end
   endtask : p1
   task automatic p2(input int s);
      go(s, CLR);
      setup(s, rj(s));
      go(s, JMP);
      repeat (1025 - 32 * int'(jmp[s][4:0])) go(s, NRM);
      chk_bit("line_end", 1'b1, s ? read_line_end : write_line_end);
      go(s, LINC);
      go(s, LHLD);
      go(s, WJMP);
      repeat (3) go(s, NRM);
      go(s, LINC);
      go(s, LHLD);
      go(s, WRST);
      setup(s, rj(s));
      go(s, WJMP);
      go(s, JMP);
      go(s, WJMP);
      go(s, CLR);
      go(s, WJMP);
      go(s, RST);
      setup(s, {1'b0, LINE_LAST_NARROW, 5'h00});
      go(s, JMP);
      go(s, LINC);
   endtask : p2

   task automatic summarize();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize

   initial begin
      seed = 29;
      {ref_clk, nrst, two_dim_mode, wide_line_mode} = 4'h0;
      for (int s = 0; s < 2; s++) begin
         st[s] = '0;
         jmp[s] = '0;
         pv[s] = 1'b0;
      end
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
      nrst = 1'b1;
      repeat (5) @(negedge ref_clk);
      chk_ptr("write_jump_addr", 32'h0, 32'(write_jump_addr));
      for (int s = 0; s < 2; s++) p1(s);
      two_dim_mode = 1'b1;
      repeat (5) @(negedge ref_clk);
      for (int s = 0; s < 2; s++) p2(s);
      chk_ptr("queued", 32'h0, 32'(q0.size() + q1.size()));
      summarize();
   end
   initial begin
      repeat (60000) @(posedge ref_clk);
      n_errors++;
      $display("[ERR] run expected done seen timeout");
      summarize();
   end
endmodule : field_memory_pointer_control_tb_top

// file: jump_addr_load.sv
`timescale 1ns/1ps
module jump_addr_load
   import field_memory_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // pin clock edge and decoded setup request
   input wire logic step,
   input wire logic start,
   input wire logic addr_strobe_n,
   input wire logic data,
   input wire logic [NBITS_W-1:0] nbits,
   // stored jump address
   output logic [JUMP_W-1:0] jump_addr,
   output logic busy
);

   logic [NBITS_W-1:0] idx_r;

   // msb first; raising the strobe early keeps the old low bits
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         jump_addr <= JUMP_RST;
         busy <= 1'b0;
         idx_r <= '0;
      end else if (step) begin
         if (busy) begin
            if (addr_strobe_n) begin
               busy <= 1'b0;
            end else begin
               jump_addr[idx_r] <= data;
               if (idx_r == '0) begin
                  busy <= 1'b0;
               end else begin
                  idx_r <= idx_r - 4'h1;
               end
            end
         end else if (start) begin
            jump_addr[nbits - 4'h1] <= data;
            busy <= 1'b1;
            idx_r <= nbits - 4'h2;
         end
      end
   end

endmodule : jump_addr_load

// file: pin_sync.sv
`timescale 1ns/1ps
module pin_sync
   import field_memory_pkg::*;
#(
   parameter int W = PIN_W
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // pins from the other party
   input wire logic [W-1:0] pin_in,
   // synchronised pins, bit 0 is the pin clock
   output logic [W-1:0] pin_q,
   output logic rise
);

   logic [W-1:0] meta_r;
   logic prev_r;

   // all pins share one chain so strobes stay aligned with their clock
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         meta_r <= '1;
         pin_q <= '1;
      end else begin
         meta_r <= pin_in;
         pin_q <= meta_r;
      end
   end

   // reset high so a clock already high at release gives no edge
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         prev_r <= 1'b1;
      end else begin
         prev_r <= pin_q[0];
      end
   end

   assign rise = pin_q[0] & ~prev_r;

endmodule : pin_sync

// file: pointer_ctl_chk.sv
`timescale 1ns/1ps
module pointer_ctl_chk
   import field_memory_pkg::*;
(
   // clock, reset, mode
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic two_dim_mode,
   // write pins
   input wire logic write_reset_strobe_n,
   input wire logic write_addr_strobe_n,
   input wire logic write_line_reset_n,
   input wire logic write_window_sel_n,
   input wire logic write_clear_strobe_n,
   input wire logic write_clock_gate_n,
   // write pointer
   input wire logic [WORD_W-1:0] write_word_addr,
   input wire logic [LINE_W-1:0] write_line,
   input wire logic [DOT_W-1:0] write_dot,
   input wire logic write_window_on,
   input wire logic write_line_end,
   input wire logic write_access,
   input wire logic [JUMP_W-1:0] write_jump_addr
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   wire logic w1d = write_access && !two_dim_mode;
   wire logic w2d = write_access && two_dim_mode && write_clear_strobe_n;
   wire logic [2:0] wk = {write_reset_strobe_n, write_addr_strobe_n,
      write_line_reset_n};
   wire logic [DOT_W-1:0] lft = {1'b0, write_jump_addr[4:0], 5'h00};
   property p_w_inc;
      w1d && wk[2:1] == 2'b11 && !write_clock_gate_n &&
      $past(write_word_addr) != FIFO_WORD_LAST
      |-> write_word_addr == $past(write_word_addr) + 19'h00001;
   endproperty
   a_w_inc: assert property (p_w_inc) else $error("inc");
   property p_w_rst;
      w1d && wk[2:1] == 2'b01 |-> write_word_addr == WORD_RST;
   endproperty
   a_w_rst: assert property (p_w_rst) else $error("reset");
   property p_w_jmp;
      w1d && wk[2:1] == 2'b00
      |-> write_word_addr == {write_jump_addr[13:0], 5'h00};
   endproperty
   a_w_jmp: assert property (p_w_jmp) else $error("jump");
   property p_w_set;
      w1d && wk[2:1] == 2'b10 |-> $stable(write_word_addr);
   endproperty
   a_w_set: assert property (p_w_set) else $error("setup");
   property p_w_lin;
      w2d && wk == 3'b110 |-> write_line == ($past(write_line) ==
      LINE_LAST_NARROW ? LINE_RST : $past(write_line) + 9'h001) &&
      write_dot == (write_window_on ? lft : DOT_RST);
   endproperty
   a_w_lin: assert property (p_w_lin) else $error("line inc");
   property p_w_hold;
      w2d && wk == 3'b010 |-> $stable(write_line) &&
      write_dot == (write_window_on ? lft : DOT_RST);
   endproperty
   a_w_hold: assert property (p_w_hold) else $error("hold");
   property p_w_clr;
      write_access && two_dim_mode && !write_clear_strobe_n
      |-> write_line == LINE_RST && write_dot == DOT_RST && !write_window_on;
   endproperty
   a_w_clr: assert property (p_w_clr) else $error("clear");
   property p_w_sat;
      w2d && wk == 3'b111 && $past(write_line_end)
      |-> write_line_end && $stable(write_dot);
   endproperty
   a_w_sat: assert property (p_w_sat) else $error("line end");
   property p_w_win;
      w2d && wk == 3'b001 |-> write_window_on == !write_window_sel_n &&
      write_line == write_jump_addr[13:5] && write_dot == lft;
   endproperty
   a_w_win: assert property (p_w_win) else $error("win jump");
   property p_w_wrst;
      w2d && wk == 3'b011 && !write_window_sel_n |-> write_dot == lft &&
      write_line == write_jump_addr[13:5] && $stable(write_window_on);
   endproperty
   a_w_wrst: assert property (p_w_wrst) else $error("win reset");
endmodule : pointer_ctl_chk

bind field_memory_pointer_control pointer_ctl_chk u_chk (.*);

// file: video_ctl_model.sv
`timescale 1ns/1ps
module video_ctl_model (
   // system clock
   input wire logic ref_clk,
   // side pins
   output logic ck,
   output logic rs_n,
   output logic as_n,
   output logic lr_n,
   output logic wn_n,
   output logic cl_n,
   output logic cg_n,
   output logic en_n,
   output logic d
);
   // window select idles high, gate and enable low
   initial {ck, rs_n, as_n, lr_n, wn_n, cl_n, cg_n, en_n, d} = 9'h0f8;
   // strobes settle two cycles ahead and hold seven past the rise
   task automatic pulse(input logic [5:0] c, input logic b);
      @(negedge ref_clk);
      {rs_n, as_n, lr_n, wn_n, cl_n, cg_n} <= c;
      d <= b;
      repeat (2) @(negedge ref_clk);
      ck <= 1'b1;
      repeat (4) @(negedge ref_clk);
      ck <= 1'b0;
      repeat (3) @(negedge ref_clk);
   endtask : pulse
endmodule : video_ctl_model
